// ---- hw/smac_top.sv ----
// Signed multiply-adder slice with Avalon-MM configuration registers
// Behaviour
// - B operands are fixed signed, fixed unsigned, or set by an input.
// - Variable B: control high means signed, low means unsigned.
// - A sign control may be registered; otherwise it acts directly.
// - B sign control may be registered; otherwise it acts directly.
// - Each registered control may add one extra pipeline stage.
// - Every control and pipeline register picks one of four clocks.
// - Every optional register picks one of three clears or none.
// - Optional shift-out carries the last multiplier's A operand.
// - Optional shift-out carries the last multiplier's B operand.
// - Adder result may be registered; otherwise sum passes through.
// - Output register picks one of four clocks and a clear or none.
// - Second product is added, subtracted, or chosen at runtime.
// - Variable direction: control high adds, low subtracts.
// - Variable A: control high means signed, low means unsigned.
// - A operands are fixed signed, fixed unsigned, or set by an input.
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module smac_top #(
  parameter int NMUL = 2,
  parameter int WA = 16,
  parameter int WB = 16,
  parameter int RES_W = 36
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Clock sources and asynchronous clears for the optional registers
  input wire logic [smac_pkg::N_CLK_SRC-1:0] clk_src_pin_in,
  input wire logic [smac_pkg::N_CLR_SRC-1:0] async_clear_in,
  // Operands and runtime controls
  input wire logic [NMUL*WA-1:0] a_operand_in,
  input wire logic [NMUL*WB-1:0] b_operand_in,
  input wire logic a_operand_signed_ctl_in,
  input wire logic b_operand_signed_ctl_in,
  input wire logic pair1_add_not_sub_in,
  // Results
  output logic [RES_W-1:0] result_out,
  output logic [WA-1:0] shiftout_a_out,
  output logic [WB-1:0] shiftout_b_out
);
  import smac_pkg::*;

  localparam int AW = NMUL*WA + 1;
  localparam int BW = NMUL*WB + 1;
  localparam int PW = WA + WB + 2;

  // Bus and configuration state
  logic waitreq_ff;
  logic [31:0] rdata_ff;
  logic [31:0] fmt_ff;
  logic [31:0] stg_a_ff;
  logic [31:0] stg_b_ff;
  logic [31:0] stg_dir_ff;
  logic [31:0] stg_out_ff;
  logic bus_req;
  logic wr_take;
  // Clock source synchronisers and edge detection
  logic [N_CLK_SRC-1:0] src_s1_ff;
  logic [N_CLK_SRC-1:0] src_s2_ff;
  logic [N_CLK_SRC-1:0] src_s3_ff;
  logic [N_CLK_SRC-1:0] tick_c;
  // Datapath
  logic [AW-1:0] a_in_q;
  logic [AW-1:0] a_path;
  logic [BW-1:0] b_in_q;
  logic [BW-1:0] b_path;
  logic dir_in_q;
  logic dir_path;
  logic a_signed_eff;
  logic b_signed_eff;
  logic add_eff;
  logic [RES_W-1:0] prod_ext [NMUL];
  logic [RES_W-1:0] sum_c;
  logic [RES_W-1:0] out_q;
  logic [31:0] status_c;

  // Merge a write into a register under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // Resolve a number format to signed or unsigned
  function automatic logic fmt_signed(input logic [1:0] fmt,
                                      input logic ctl);
    logic r;
    r = (fmt == NUM_SIGNED);
    if (fmt == NUM_VARIABLE) r = ctl;
    return r;
  endfunction

  // Avalon handshake: waitrequest drops for one cycle per request
  assign bus_req = avs_read_in | avs_write_in;
  assign wr_take = avs_write_in & ~waitreq_ff;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      waitreq_ff <= 1'b1;
    end else begin
      waitreq_ff <= ~(bus_req & waitreq_ff);
    end
  end

  // Read data is captured as waitrequest drops
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read_in & waitreq_ff) begin
      unique case (avs_address_in)
        REG_FMT: rdata_ff <= fmt_ff;
        REG_STG_A: rdata_ff <= stg_a_ff;
        REG_STG_B: rdata_ff <= stg_b_ff;
        REG_STG_DIR: rdata_ff <= stg_dir_ff;
        REG_STG_OUT: rdata_ff <= stg_out_ff;
        REG_STATUS: rdata_ff <= status_c;
        REG_RESULT: rdata_ff <= result_out[31:0];
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers, written when the write is accepted
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fmt_ff <= FMT_RESET;
      stg_a_ff <= STG_REG_RESET;
      stg_b_ff <= STG_REG_RESET;
      stg_dir_ff <= STG_REG_RESET;
      stg_out_ff <= {27'h0, STG_RESET};
    end else if (wr_take) begin
      if (avs_address_in == REG_FMT) begin
        fmt_ff <= be_merge(fmt_ff, avs_writedata_in, avs_byteenable_in)
                  & 32'h0000_033f;
      end
      if (avs_address_in == REG_STG_A) begin
        stg_a_ff <= be_merge(stg_a_ff, avs_writedata_in, avs_byteenable_in)
                    & 32'h0000_1f1f;
      end
      if (avs_address_in == REG_STG_B) begin
        stg_b_ff <= be_merge(stg_b_ff, avs_writedata_in, avs_byteenable_in)
                    & 32'h0000_1f1f;
      end
      if (avs_address_in == REG_STG_DIR) begin
        stg_dir_ff <= be_merge(stg_dir_ff, avs_writedata_in,
                               avs_byteenable_in) & 32'h0000_1f1f;
      end
      if (avs_address_in == REG_STG_OUT) begin
        stg_out_ff <= be_merge(stg_out_ff, avs_writedata_in,
                               avs_byteenable_in) & 32'h0000_001f;
      end
    end
  end

  assign avs_waitrequest_out = waitreq_ff;
  assign avs_readdata_out = rdata_ff;

  // Clock sources are foreign: two flops, then rising-edge ticks
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      src_s1_ff <= '0;
      src_s2_ff <= '0;
      src_s3_ff <= '0;
    end else begin
      src_s1_ff <= clk_src_pin_in;
      src_s2_ff <= src_s1_ff;
      src_s3_ff <= src_s2_ff;
    end
  end

  for (genvar g = 0; g < N_CLK_SRC; g++) begin : g_tick
    assign tick_c[g] = src_s2_ff[g] & ~src_s3_ff[g];
  end

  smac_clk_if u_cif (
    .clk(core_clk_in),
    .rst(rst_in)
  );
  assign u_cif.tick = tick_c;
  assign u_cif.clr = async_clear_in;

  // A sign rides with the A operands through the same stages
  smac_stage #(.W(AW)) u_a_in (
    .cif(u_cif),
    .cfg_in(stg_a_ff[4:0]),
    .d_in({a_operand_signed_ctl_in, a_operand_in}),
    .q_out(a_in_q)
  );
  smac_stage #(.W(AW)) u_a_pipe (
    .cif(u_cif),
    .cfg_in(stg_a_ff[STG_PIPE_LSB +: 5]),
    .d_in(a_in_q),
    .q_out(a_path)
  );

  // B sign rides with the B operands through the same stages
  smac_stage #(.W(BW)) u_b_in (
    .cif(u_cif),
    .cfg_in(stg_b_ff[4:0]),
    .d_in({b_operand_signed_ctl_in, b_operand_in}),
    .q_out(b_in_q)
  );
  smac_stage #(.W(BW)) u_b_pipe (
    .cif(u_cif),
    .cfg_in(stg_b_ff[STG_PIPE_LSB +: 5]),
    .d_in(b_in_q),
    .q_out(b_path)
  );

  // Direction control stages for the first pair
  smac_stage #(.W(1)) u_dir_in (
    .cif(u_cif),
    .cfg_in(stg_dir_ff[4:0]),
    .d_in(pair1_add_not_sub_in),
    .q_out(dir_in_q)
  );
  smac_stage #(.W(1)) u_dir_pipe (
    .cif(u_cif),
    .cfg_in(stg_dir_ff[STG_PIPE_LSB +: 5]),
    .d_in(dir_in_q),
    .q_out(dir_path)
  );

  // Effective sign and direction after format selection
  assign a_signed_eff = fmt_signed(fmt_ff[FMT_A_LSB +: 2],
                                   a_path[AW-1]);
  assign b_signed_eff = fmt_signed(fmt_ff[FMT_B_LSB +: 2],
                                   b_path[BW-1]);
  always_comb begin
    add_eff = (fmt_ff[FMT_DIR_LSB +: 2] != DIR_SUB);
    if (fmt_ff[FMT_DIR_LSB +: 2] == DIR_VARIABLE) begin
      add_eff = dir_path;
    end
  end

  // Two's complement products, operands extended by their sign mode
  for (genvar m = 0; m < NMUL; m++) begin : g_mul
    logic signed [WA:0] ax;
    logic signed [WB:0] bx;
    logic signed [PW-1:0] prod;
    assign ax = {a_signed_eff & a_path[m*WA + WA-1], a_path[m*WA +: WA]};
    assign bx = {b_signed_eff & b_path[m*WB + WB-1], b_path[m*WB +: WB]};
    assign prod = ax * bx;
    assign prod_ext[m] = RES_W'(prod);
  end

  // Adder: second product added or subtracted, later ones added
  always_comb begin
    sum_c = prod_ext[0];
    for (int k = 1; k < NMUL; k++) begin
      if (k == 1 && !add_eff) begin
        sum_c = sum_c - prod_ext[k];
      end else begin
        sum_c = sum_c + prod_ext[k];
      end
    end
  end

  // Optional adder output register
  smac_stage #(.W(RES_W)) u_out (
    .cif(u_cif),
    .cfg_in(stg_out_ff[4:0]),
    .d_in(sum_c),
    .q_out(out_q)
  );

  // Status shows the resolved controls
  assign status_c = {29'h0000_0000, add_eff, b_signed_eff, a_signed_eff};

  // Output flops: result and the two shift-out chains
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= '0;
      shiftout_a_out <= '0;
      shiftout_b_out <= '0;
    end else begin
      result_out <= out_q;
      shiftout_a_out <= fmt_ff[FMT_SHA_BIT] ?
                        a_path[(NMUL-1)*WA +: WA] : '0;
      shiftout_b_out <= fmt_ff[FMT_SHB_BIT] ?
                        b_path[(NMUL-1)*WB +: WB] : '0;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_req_wait;
    bus_req && waitreq_ff;
  endsequence
  sequence s_ack_once;
    !waitreq_ff ##1 waitreq_ff;
  endsequence

  a_bus_answer: assert property (s_req_wait |=> s_ack_once)
    else $error("bus answer not a single cycle");
  a_b_var_sign: assert property (
    fmt_ff[FMT_B_LSB +: 2] == NUM_VARIABLE && !stg_b_ff[STG_EN_BIT] &&
      !stg_b_ff[STG_PIPE_LSB] |-> b_signed_eff == b_operand_signed_ctl_in)
    else $error("variable B sign not followed");
  a_b_fixed_fmt: assert property (
    fmt_ff[FMT_B_LSB +: 2] == NUM_UNSIGNED |-> !b_signed_eff)
    else $error("fixed unsigned B treated as signed");
  a_a_var_sign: assert property (
    fmt_ff[FMT_A_LSB +: 2] == NUM_VARIABLE && !stg_a_ff[STG_EN_BIT] &&
      !stg_a_ff[STG_PIPE_LSB] |-> a_signed_eff == a_operand_signed_ctl_in)
    else $error("variable A sign not followed");
  a_dir_var: assert property (
    fmt_ff[FMT_DIR_LSB +: 2] == DIR_VARIABLE && !stg_dir_ff[STG_EN_BIT] &&
      !stg_dir_ff[STG_PIPE_LSB] |-> add_eff == pair1_add_not_sub_in)
    else $error("variable direction not followed");
  a_shift_a_off: assert property (
    !fmt_ff[FMT_SHA_BIT] |=> shiftout_a_out == '0)
    else $error("disabled A shift-out not zero");
  a_shift_b_on: assert property (
    fmt_ff[FMT_SHB_BIT] |=>
      shiftout_b_out == $past(b_path[(NMUL-1)*WB +: WB]))
    else $error("B shift-out wrong");
  a_result_pass: assert property (
    !stg_out_ff[STG_EN_BIT] |=> result_out == $past(sum_c))
    else $error("unregistered sum not presented");
endmodule

// ---- hw/smac_pkg.sv ----
// Shared constants and types for the signed multiply-adder slice
package smac_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] REG_FMT = 5'h00;
  localparam logic [4:0] REG_STG_A = 5'h04;
  localparam logic [4:0] REG_STG_B = 5'h08;
  localparam logic [4:0] REG_STG_DIR = 5'h0c;
  localparam logic [4:0] REG_STG_OUT = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_RESULT = 5'h18;
  // Format register fields
  localparam int FMT_A_LSB = 0;
  localparam int FMT_B_LSB = 2;
  localparam int FMT_DIR_LSB = 4;
  localparam int FMT_SHA_BIT = 8;
  localparam int FMT_SHB_BIT = 9;
  localparam logic [31:0] FMT_RESET = 32'h0000_0000;
  // Number format and direction codes
  localparam logic [1:0] NUM_SIGNED = 2'h0;
  localparam logic [1:0] NUM_UNSIGNED = 2'h1;
  localparam logic [1:0] NUM_VARIABLE = 2'h2;
  localparam logic [1:0] DIR_ADD = 2'h0;
  localparam logic [1:0] DIR_SUB = 2'h1;
  localparam logic [1:0] DIR_VARIABLE = 2'h2;
  // Stage configuration: enable, clock source, clear source
  localparam int STG_EN_BIT = 0;
  localparam int STG_CLK_LSB = 1;
  localparam int STG_CLR_LSB = 3;
  localparam int STG_PIPE_LSB = 8;
  localparam logic [1:0] CLR_NONE = 2'h3;
  localparam logic [4:0] STG_RESET = 5'h18;
  localparam logic [31:0] STG_REG_RESET = 32'h0000_1818;
  // Status register bits
  localparam int ST_A_SIGNED = 0;
  localparam int ST_B_SIGNED = 1;
  localparam int ST_ADD = 2;
  // Source counts
  localparam int N_CLK_SRC = 4;
  localparam int N_CLR_SRC = 3;
  typedef logic [4:0] smac_stg_cfg_t;
endpackage

// ---- hw/smac_clk_if.sv ----
// Clock-source ticks and clear sources shared by every optional register
`timescale 1ns/1ns
interface smac_clk_if (
  input wire logic clk,
  input wire logic rst
);
  logic [3:0] tick;
  logic [2:0] clr;
  modport stage (input clk, input rst, input tick, input clr);
  modport drive (output tick, output clr);
endinterface

// ---- hw/smac_stage.sv ----
// One optional register stage with selectable clock source and clear
`timescale 1ns/1ns
module smac_stage #(
  parameter int W = 1
) (
  // Shared clocking
  smac_clk_if.stage cif,
  // Configuration
  input wire smac_pkg::smac_stg_cfg_t cfg_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  import smac_pkg::*;

  logic en;
  logic [1:0] csel;
  logic [1:0] rsel;
  logic clr_hit;
  logic arst;
  logic [W-1:0] q_ff;

  // Pick the selected clear, code three means none
  function automatic logic clr_pick(input logic [1:0] sel,
                                    input logic [2:0] clr);
    logic r;
    r = 1'b0;
    if (sel == 2'h0) r = clr[0];
    else if (sel == 2'h1) r = clr[1];
    else if (sel == 2'h2) r = clr[2];
    return r;
  endfunction

  // Configuration decode
  assign en = cfg_in[STG_EN_BIT];
  assign csel = cfg_in[STG_CLK_LSB +: 2];
  assign rsel = cfg_in[STG_CLR_LSB +: 2];
  assign clr_hit = clr_pick(rsel, cif.clr);
  assign arst = cif.rst | clr_hit;

  // Stage register, cleared at once by its selected clear
  always_ff @(posedge cif.clk or posedge arst) begin
    if (arst) begin
      q_ff <= '0;
    end else if (cif.tick[csel]) begin
      q_ff <= d_in;
    end
  end

  // Bypass when the stage is switched off
  assign q_out = en ? q_ff : d_in;

  a_stage_clear: assert property (
    @(posedge cif.clk) disable iff (cif.rst)
    clr_hit |-> q_ff == '0)
    else $error("stage not held clear");
  a_stage_tick: assert property (
    @(posedge cif.clk) disable iff (cif.rst)
    (cif.tick[csel] && !clr_hit) |=> (clr_hit || q_ff == $past(d_in)))
    else $error("stage missed its clock source");
endmodule

// ---- tb/smac_user_model.sv ----
// Model of the user logic that supplies operands and runtime controls
`timescale 1ns/1ns
module smac_user_model (
  // Clock
  input wire logic clk_in,
  // Values requested by the bench
  input wire logic [31:0] a_req_in,
  input wire logic [31:0] b_req_in,
  input wire logic [2:0] ctl_req_in,
  // Values presented to the slice
  output logic [31:0] a_out = 32'h0,
  output logic [31:0] b_out = 32'h0,
  output logic a_signed_out = 1'b0,
  output logic b_signed_out = 1'b0,
  output logic add_not_sub_out = 1'b0
);
  // Operands leave a flop, as the surrounding logic launches them
  always @(posedge clk_in) begin
    a_out <= a_req_in;
    b_out <= b_req_in;
  end
  // Sign levels: high means signed, low means unsigned
  always @(posedge clk_in) begin
    a_signed_out <= ctl_req_in[0];
    b_signed_out <= ctl_req_in[1];
  end
  // Direction level: high adds, low subtracts
  always @(posedge clk_in) begin
    add_not_sub_out <= ctl_req_in[2];
  end
endmodule

// ---- tb/smac_top_bench.sv ----
// Self-checking bench for the multiply-adder slice
`timescale 1ns/1ns
module smac_top_bench;
  import smac_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wreq;
  logic [4:0] addr = 5'h0;
  logic [31:0] wdata = 32'h0, rdata, rword, a_rq = 32'h0, b_rq = 32'h0;
  logic [3:0] be = 4'h0, src = 4'h0;
  logic [2:0] clr = 3'h0, c_rq = 3'h0;
  logic [31:0] a_d, b_d;
  logic sa_d, sb_d, ad_d;
  logic [35:0] res;
  logic [15:0] sha, shb;
  int err_total, checks_done;

  // Clock at 20 MHz
  initial forever #25 clk = ~clk;

  smac_user_model user (.clk_in(clk), .a_req_in(a_rq), .b_req_in(b_rq),
    .ctl_req_in(c_rq), .a_out(a_d), .b_out(b_d), .a_signed_out(sa_d),
    .b_signed_out(sb_d), .add_not_sub_out(ad_d));

  smac_top #(.NMUL(2), .WA(16), .WB(16), .RES_W(36)) dut (
    .core_clk_in(clk), .rst_in(rst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .clk_src_pin_in(src),
    .async_clear_in(clr), .a_operand_in(a_d), .b_operand_in(b_d),
    .a_operand_signed_ctl_in(sa_d), .b_operand_signed_ctl_in(sb_d),
    .pair1_add_not_sub_in(ad_d), .result_out(res),
    .shiftout_a_out(sha), .shiftout_b_out(shb));

  task automatic chk_res(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t result %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] ad,
                     input logic [31:0] d, input logic [3:0] e);
    int n;
    n = 0;
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    be <= e;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("[FAIL] %0t bus answer timed out", $time);
    end
    rword = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0, 4'hf);
    chk_reg(rword, exp);
  endtask

  // Present operands; the model adds one edge, the output flop one more
  task automatic ops(input logic [31:0] a, input logic [31:0] b,
                     input logic [2:0] c);
    @(posedge clk);
    a_rq <= a;
    b_rq <= b;
    c_rq <= c;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // One rising edge on a clock-source pin, held long enough to be seen
  task automatic pulse(input int s);
    @(posedge clk);
    src[s] <= 1'b1;
    repeat (3) @(posedge clk);
    src[s] <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  // Effective sign and direction: {add, b signed, a signed}
  function automatic logic [2:0] st(input logic [2:0] c, input logic [5:0] f);
    st[0] = f[1:0] == NUM_SIGNED || (f[1:0] == NUM_VARIABLE && c[0]);
    st[1] = f[3:2] == NUM_SIGNED || (f[3:2] == NUM_VARIABLE && c[1]);
    st[2] = f[5:4] != DIR_SUB && (f[5:4] != DIR_VARIABLE || c[2]);
  endfunction

  function automatic logic [35:0] ex(input logic [31:0] a,
                                     input logic [31:0] b,
                                     input logic [2:0] c,
                                     input logic [5:0] f);
    logic signed [35:0] x0, x1, y0, y1;
    logic [2:0] s;
    s = st(c, f);
    x0 = {{20{s[0] & a[15]}}, a[15:0]};
    x1 = {{20{s[0] & a[31]}}, a[31:16]};
    y0 = {{20{s[1] & b[15]}}, b[15:0]};
    y1 = {{20{s[1] & b[31]}}, b[31:16]};
    return s[2] ? x0 * y0 + x1 * y1 : x0 * y0 - x1 * y1;
  endfunction

  task automatic t_reset();
    rd_chk(REG_FMT, FMT_RESET);
    for (int i = 1; i < 4; i++) rd_chk(5'(i * 4), STG_REG_RESET);
    rd_chk(REG_STG_OUT, {27'h0, STG_RESET});
    bus(1'b1, 5'h1c, 32'hffff_ffff, 4'hf);
    rd_chk(5'h1c, 32'h0);
    rd_chk(REG_FMT, FMT_RESET);
    $display("test reset done");
  endtask

  // Every format and direction code, each control level
  task automatic t_formats();
    logic [5:0] f;
    logic [2:0] c;
    logic [35:0] e;
    for (int i = 0; i < 128; i++) begin
      f = i[5:0];
      c = i[6] ? 3'h5 : 3'h2;
      bus(1'b1, REG_FMT, {26'h0, f}, 4'hf);
      ops(32'h8003_fff0, 32'h7ffe_c001, c);
      e = ex(32'h8003_fff0, 32'h7ffe_c001, c, f);
      chk_res(res, e);
      rd_chk(REG_STATUS, {29'h0, st(c, f)});
    end
    $display("test formats done");
  endtask

  // Stage on source s holds until its tick; m marks what it holds
  task automatic t_stage(input logic [4:0] ad, input int s,
                         input logic [3:0] m, input logic p);
    logic [31:0] a0, b0, a1, b1;
    logic [2:0] c0, c1, cv;
    logic [4:0] g;
    logic [35:0] old;
    a0 = 32'h0005_fffd;
    b0 = 32'h0007_0009;
    c0 = 3'h7;
    a1 = 32'h8000_0011;
    b1 = 32'hfff0_0003;
    c1 = 3'h0;
    g = {2'h3, s[1:0], 1'b1};
    bus(1'b1, REG_FMT, 32'h2a, 4'hf);
    bus(1'b1, ad, {16'h0, p ? {3'h0, g} : 8'h18, 3'h0, g}, 4'hf);
    ops(a0, b0, c0);
    pulse(s);
    if (p) pulse(s);
    ops(a1, b1, c1);
    pulse(s ^ 1);
    cv = m[2:0];
    old = m[3] ? ex(a0, b0, c0, 6'h2a) :
          ex(m[0] ? a0 : a1, m[1] ? b0 : b1, cv, 6'h2a);
    chk_res(res, old);
    if (p) begin
      pulse(s);
      chk_res(res, old);
    end
    pulse(s);
    chk_res(res, ex(a1, b1, c1, 6'h2a));
    bus(1'b1, ad, STG_REG_RESET, 4'hf);
    $display("test stage %0h done", ad);
  endtask

  // Each clear source empties a stage at once; the next source leaves it alone
  task automatic t_clear();
    logic [35:0] e;
    e = ex(32'h0003_0002, 32'h0004_0005, 3'h0, 6'h0);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, REG_FMT, 32'h0, 4'hf);
      ops(32'h0003_0002, 32'h0004_0005, 3'h0);
      pulse(0);
      bus(1'b1, REG_STG_A, {16'h0, 8'h18, 3'h0, k[1:0], 3'h1}, 4'hf);
      @(posedge clk);
      clr[(k + 1) % 3] <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk_res(res, e);
      rd_chk(REG_RESULT, e[31:0]);
      clr[k] <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk_res(res, 36'h0);
      @(posedge clk);
      clr <= 3'h0;
      pulse(0);
      chk_res(res, e);
      bus(1'b1, REG_STG_A, STG_REG_RESET, 4'hf);
    end
    $display("test clear done");
  endtask

  task automatic t_shift();
    ops(32'hbeef_1234, 32'hcafe_5678, 3'h0);
    bus(1'b1, REG_FMT, 32'h0000_03ff, 4'h2);
    ops(32'hbeef_1234, 32'hcafe_5678, 3'h0);
    rd_chk(REG_FMT, 32'h0000_0300);
    chk_reg({16'h0, sha}, 32'h0000_beef);
    chk_reg({16'h0, shb}, 32'h0000_cafe);
    bus(1'b1, REG_FMT, 32'h0, 4'hf);
    ops(32'hbeef_1234, 32'hcafe_5678, 3'h0);
    chk_reg({sha, shb}, 32'h0);
    $display("test shift done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well past the expected length of all tests
  initial begin
    #1000000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_reg({31'h0, wreq}, 32'h1);
    chk_res(res, 36'h0);
    repeat (7) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_formats();
    t_stage(REG_STG_A, 1, 4'h1, 1'b1);
    t_stage(REG_STG_B, 3, 4'h2, 1'b0);
    t_stage(REG_STG_DIR, 0, 4'h4, 1'b1);
    t_stage(REG_STG_OUT, 2, 4'h8, 1'b0);
    t_clear();
    t_shift();
    conclude();
  end
endmodule
